// [design/cpsr_defines.vh]
// shared offsets, field positions and reset values for the core register block
`ifndef CPSR_DEFINES_VH
`define CPSR_DEFINES_VH
// register byte addresses on the bus
`define CPSR_ADDR_ACC    12'h000
`define CPSR_ADDR_PCLO   12'h004
`define CPSR_ADDR_TPLO   12'h008
`define CPSR_ADDR_TPHI   12'h00c
`define CPSR_ADDR_TLATCH 12'h010
`define CPSR_ADDR_FLAG   12'h014
`define CPSR_ADDR_PCFULL 12'h018
// flag bit positions
`define CPSR_BIT_C   0
`define CPSR_BIT_AC  1
`define CPSR_BIT_Z   2
`define CPSR_BIT_OV  3
`define CPSR_BIT_PDF 4
`define CPSR_BIT_TO  5
// writable arithmetic flag mask
`define CPSR_ARITH_MASK 8'h0f
// reset values
`define CPSR_RST_BYTE 8'h00
// alu operation codes
`define CPSR_OP_ADD  4'h0
`define CPSR_OP_ADC  4'h1
`define CPSR_OP_SUB  4'h2
`define CPSR_OP_SBC  4'h3
`define CPSR_OP_AND  4'h4
`define CPSR_OP_OR   4'h5
`define CPSR_OP_XOR  4'h6
`define CPSR_OP_RRC  4'h7
`define CPSR_OP_RLC  4'h8
`define CPSR_OP_INC  4'h9
`define CPSR_OP_DEC  4'ha
`define CPSR_OP_MOV  4'hb
// register select codes for the execution unit
`define CPSR_SEL_ACC  3'h0
`define CPSR_SEL_PCLO 3'h1
`define CPSR_SEL_TPLO 3'h2
`define CPSR_SEL_TPHI 3'h3
`define CPSR_SEL_FLAG 3'h4
`endif

// [design/cpsr_regs.v]
// core working registers: accumulator, pc low, table pointers, flags
//
// Notes on behaviour
// [RQ1] every alu result is written into the working accumulator.
// [RQ2] no register-to-register move exists; data passes the accumulator.
// [RQ3] writing pc low jumps within the current page, upper bits kept.
// [RQ4] a write to pc low that jumps inserts one dummy pipeline cycle.
// [RQ5] table pointer low and high form the table address, inc/dec-able.
// [RQ6] software loads the table pointers before any table read.
// [RQ7] a table read puts the high byte in the latch, low byte to dest.
// [RQ8] z, ov, ac, c are writable; power-down and time-out are read only.
// [RQ9] writes to the flag register leave time-out and power-down alone.
// [RQ10] carry is set by add carry or subtract no-borrow, and by rotates.
// [RQ11] half carry is set by low-nibble carry or no nibble borrow.
// [RQ12] zero is set on an all-zero result and cleared otherwise; rotates leave zero unchanged here.
// [RQ13] overflow is the xor of carry into and out of the top bit.
// [RQ14] power-down clears at reset and clear-watchdog, sets on sleep.
// [RQ15] time-out sets on watchdog expiry, clears at reset, clear, sleep.
// [RQ16] the flag register is never saved automatically on call or irq.
// [RQ17] flag layout: to 5, pdf 4, ov 3, z 2, ac 1, c 0; 7:6 read zero.
//
// The AHB-Lite interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "cpsr_defines.vh"

module cpsr_regs #(
  parameter PC_WIDTH = 12
) (
  // clock, reset, enable
  input  wire                CLOCK_IN,
  input  wire                RST_N_IN,
  input  wire                CLK_EN_IN,
  // ahb-lite slave
  input  wire                HSEL_IN,
  input  wire [11:0]         HADDR_IN,
  input  wire [1:0]          HTRANS_IN,
  input  wire                HWRITE_IN,
  input  wire [2:0]          HSIZE_IN,
  input  wire [31:0]         HWDATA_IN,
  input  wire                HREADY_IN,
  output wire [31:0]         HRDATA_OUT,
  output wire                HREADYOUT_OUT,
  output wire                HRESP_OUT,
  // execution unit: alu operation
  input  wire                ALU_EN_IN,
  input  wire [3:0]          ALU_OP_IN,
  input  wire [7:0]          ALU_OPERAND_IN,
  // execution unit: accumulator to register store
  input  wire                STORE_EN_IN,
  input  wire [2:0]          STORE_SEL_IN,
  // execution unit: table pointer step and table read
  input  wire                TP_INC_IN,
  input  wire                TP_DEC_IN,
  input  wire                TABLE_RD_IN,
  input  wire [15:0]         TABLE_WORD_IN,
  // execution unit: system events
  input  wire                CLEAR_WATCHDOG_INSTRUCTION_IN,
  input  wire                SLEEP_IN,
  input  wire                WDT_EXPIRE_IN,
  // execution unit: program counter
  input  wire                PC_ADVANCE_IN,
  // outputs toward the core
  output reg  [7:0]          ACC_OUT,
  output reg  [PC_WIDTH-1:0] PC_OUT,
  output reg  [15:0]         TABLE_ADDR_OUT,
  output reg  [7:0]          TABLE_LOW_OUT,
  output reg                 TABLE_LOW_VLD_OUT,
  output reg  [7:0]          FLAGS_OUT,
  output reg                 DUMMY_CYCLE_OUT
);

  // core registers
  reg [7:0] tplo;
  reg [7:0] tphi;
  reg [7:0] tlatch;
  reg       fc, fac, fz, fov, fpdf, fto;
  // ahb address phase capture
  reg        ph_act;
  reg        ph_wr;
  reg [11:0] ph_addr;
  reg [31:0] rdata;

  // flag register image, upper two bits read as zero
  function [7:0] flag_byte;
    input to, power_down_flag, ov, z, ac, c;
    begin
      flag_byte = {2'b00, to, power_down_flag, ov, z, ac, c}; // RQ17
    end
  endfunction

  // alu result, carry, half carry and overflow in one place
  reg [8:0] sum;
  reg [4:0] nib;
  reg [7:0] res;
  reg       nc, nac, nov, arith, rot;
  reg       cin7;
  always @* begin
    sum   = 9'h000;
    nib   = 5'h00;
    res   = 8'h00;
    nc    = fc;
    nac   = fac;
    nov   = fov;
    arith = 1'b0;
    rot   = 1'b0;
    cin7  = 1'b0;
    case (ALU_OP_IN)
      `CPSR_OP_ADD, `CPSR_OP_ADC: begin
        sum  = {1'b0, ACC_OUT} + {1'b0, ALU_OPERAND_IN} +
               {8'h00, (ALU_OP_IN == `CPSR_OP_ADC) & fc};
        nib  = {1'b0, ACC_OUT[3:0]} + {1'b0, ALU_OPERAND_IN[3:0]} +
               {4'h0, (ALU_OP_IN == `CPSR_OP_ADC) & fc};
        arith = 1'b1;
      end
      `CPSR_OP_SUB, `CPSR_OP_SBC: begin
        // subtract as add of complement: carry out means no borrow
        sum  = {1'b0, ACC_OUT} + {1'b0, ~ALU_OPERAND_IN} +
               {8'h00, (ALU_OP_IN == `CPSR_OP_SUB) | fc};
        nib  = {1'b0, ACC_OUT[3:0]} + {1'b0, ~ALU_OPERAND_IN[3:0]} +
               {4'h0, (ALU_OP_IN == `CPSR_OP_SUB) | fc};
        arith = 1'b1;
      end
      `CPSR_OP_AND: res = ACC_OUT & ALU_OPERAND_IN;
      `CPSR_OP_OR:  res = ACC_OUT | ALU_OPERAND_IN;
      `CPSR_OP_XOR: res = ACC_OUT ^ ALU_OPERAND_IN;
      `CPSR_OP_RRC: begin
        res = {fc, ALU_OPERAND_IN[7:1]};
        nc  = ALU_OPERAND_IN[0];
        rot = 1'b1;
      end
      `CPSR_OP_RLC: begin
        res = {ALU_OPERAND_IN[6:0], fc};
        nc  = ALU_OPERAND_IN[7];
        rot = 1'b1;
      end
      `CPSR_OP_INC: res = ALU_OPERAND_IN + 8'h01;
      `CPSR_OP_DEC: res = ALU_OPERAND_IN - 8'h01;
      `CPSR_OP_MOV: res = ALU_OPERAND_IN;
      default:      res = ACC_OUT;
    endcase
    if (arith) begin
      res  = sum[7:0];
      nc   = sum[8]; // RQ10
      nac  = nib[4]; // RQ11
      // carry into bit 7 recovered from the operand and result bits
      cin7 = sum[7] ^ ACC_OUT[7] ^
             (ALU_OP_IN[1] ? ~ALU_OPERAND_IN[7] : ALU_OPERAND_IN[7]);
      nov  = cin7 ^ sum[8]; // RQ13
    end
  end

  // ahb response: zero wait state, always okay
  assign HREADYOUT_OUT = 1'b1;
  assign HRESP_OUT     = 1'b0;
  assign HRDATA_OUT    = rdata;

  wire ahb_take = HSEL_IN & HREADY_IN & HTRANS_IN[1];
  wire ahb_wr   = ph_act & ph_wr;
  wire [7:0] wbyte = HWDATA_IN[7:0];
  wire core_flag_wr = STORE_EN_IN & (STORE_SEL_IN == `CPSR_SEL_FLAG);
  wire bus_flag_wr  = ahb_wr & (ph_addr == `CPSR_ADDR_FLAG);
  wire core_pc_wr   = STORE_EN_IN & (STORE_SEL_IN == `CPSR_SEL_PCLO);
  wire bus_pc_wr    = ahb_wr & (ph_addr == `CPSR_ADDR_PCLO);

  // bus address phase capture and read data
  always @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      ph_act  <= 1'b0;
      ph_wr   <= 1'b0;
      ph_addr <= 12'h000;
      rdata   <= 32'h00000000;
    end else if (CLK_EN_IN) begin
      ph_act  <= ahb_take;
      ph_wr   <= HWRITE_IN;
      ph_addr <= HADDR_IN;
      if (ahb_take & ~HWRITE_IN) begin
        case (HADDR_IN)
          `CPSR_ADDR_ACC:    rdata <= {24'h000000, ACC_OUT};
          `CPSR_ADDR_PCLO:   rdata <= {24'h000000, PC_OUT[7:0]};
          `CPSR_ADDR_TPLO:   rdata <= {24'h000000, tplo};
          `CPSR_ADDR_TPHI:   rdata <= {24'h000000, tphi};
          `CPSR_ADDR_TLATCH: rdata <= {24'h000000, tlatch};
          `CPSR_ADDR_FLAG:   rdata <= {24'h000000, FLAGS_OUT};
          `CPSR_ADDR_PCFULL: rdata <= {{(32-PC_WIDTH){1'b0}}, PC_OUT};
          default:           rdata <= 32'h00000000;
        endcase
      end
    end
  end

  // accumulator: alu results land here, no path between other registers
  always @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      ACC_OUT <= `CPSR_RST_BYTE;
    end else if (CLK_EN_IN) begin
      if (ALU_EN_IN) begin
        ACC_OUT <= res; // RQ1 RQ2
      end else if (ahb_wr & (ph_addr == `CPSR_ADDR_ACC)) begin
        ACC_OUT <= wbyte;
      end
    end
  end

  // program counter: pc low write jumps in page and costs one dummy cycle
  always @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      PC_OUT          <= {PC_WIDTH{1'b0}};
      DUMMY_CYCLE_OUT <= 1'b0;
    end else if (CLK_EN_IN) begin
      DUMMY_CYCLE_OUT <= core_pc_wr | bus_pc_wr; // RQ4
      if (core_pc_wr) begin
        PC_OUT <= {PC_OUT[PC_WIDTH-1:8], ACC_OUT}; // RQ3 RQ2
      end else if (bus_pc_wr) begin
        PC_OUT <= {PC_OUT[PC_WIDTH-1:8], wbyte}; // RQ3
      end else if (PC_ADVANCE_IN & ~DUMMY_CYCLE_OUT) begin
        // the dummy cycle holds the counter while the new fetch starts
        PC_OUT <= PC_OUT + {{(PC_WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end

  // table pointers and table high latch
  always @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      tplo              <= `CPSR_RST_BYTE;
      tphi              <= `CPSR_RST_BYTE;
      tlatch            <= `CPSR_RST_BYTE;
      TABLE_LOW_OUT     <= `CPSR_RST_BYTE;
      TABLE_LOW_VLD_OUT <= 1'b0;
    end else if (CLK_EN_IN) begin
      TABLE_LOW_VLD_OUT <= TABLE_RD_IN;
      if (TABLE_RD_IN) begin
        tlatch        <= TABLE_WORD_IN[15:8]; // RQ7
        TABLE_LOW_OUT <= TABLE_WORD_IN[7:0]; // RQ7
      end
      // increment and decrement carry across the pointer pair
      if (TP_INC_IN) begin
        {tphi, tplo} <= {tphi, tplo} + 16'h0001; // RQ5
      end else if (TP_DEC_IN) begin
        {tphi, tplo} <= {tphi, tplo} - 16'h0001; // RQ5
      end else if (STORE_EN_IN & (STORE_SEL_IN == `CPSR_SEL_TPLO)) begin
        tplo <= ACC_OUT;
      end else if (STORE_EN_IN & (STORE_SEL_IN == `CPSR_SEL_TPHI)) begin
        tphi <= ACC_OUT;
      end else if (ahb_wr & (ph_addr == `CPSR_ADDR_TPLO)) begin
        tplo <= wbyte;
      end else if (ahb_wr & (ph_addr == `CPSR_ADDR_TPHI)) begin
        tphi <= wbyte;
      end
    end
  end

  // arithmetic flags: alu update wins over a direct write
  always @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      fc  <= 1'b0;
      fac <= 1'b0;
      fz  <= 1'b0;
      fov <= 1'b0;
    end else if (CLK_EN_IN) begin
      if (ALU_EN_IN) begin
        fc  <= nc; // RQ10
        fac <= nac; // RQ11
        fov <= nov; // RQ13
        if (~rot) begin
          fz <= (res == 8'h00); // RQ12
        end
      end else if (core_flag_wr | bus_flag_wr) begin
        // only the low four bits are writable
        fc  <= core_flag_wr ? ACC_OUT[`CPSR_BIT_C]  : wbyte[`CPSR_BIT_C]; // RQ8
        fac <= core_flag_wr ? ACC_OUT[`CPSR_BIT_AC] : wbyte[`CPSR_BIT_AC];
        fz  <= core_flag_wr ? ACC_OUT[`CPSR_BIT_Z]  : wbyte[`CPSR_BIT_Z];
        fov <= core_flag_wr ? ACC_OUT[`CPSR_BIT_OV] : wbyte[`CPSR_BIT_OV];
      end
    end
  end

  // system flags: no store path reaches them, and nothing saves them
  always @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      fpdf <= 1'b0; // RQ14
      fto  <= 1'b0; // RQ15
    end else if (CLK_EN_IN) begin
      if (SLEEP_IN) begin
        fpdf <= 1'b1; // RQ14 RQ9
      end else if (CLEAR_WATCHDOG_INSTRUCTION_IN) begin
        fpdf <= 1'b0; // RQ14
      end
      // an expiry in the same cycle as a clear is kept
      if (WDT_EXPIRE_IN) begin
        fto <= 1'b1; // RQ15
      end else if (CLEAR_WATCHDOG_INSTRUCTION_IN | SLEEP_IN) begin
        fto <= 1'b0; // RQ15 RQ9
      end
    end
  end

  // combinational views of the registers for the core
  always @* begin
    FLAGS_OUT      = flag_byte(fto, fpdf, fov, fz, fac, fc); // RQ16
    TABLE_ADDR_OUT = {tphi, tplo}; // RQ5
  end

endmodule // cpsr_regs
`default_nettype wire

// [tb/cpsr_regs_chk.sv]
// assertion checker for the core register block ports
`timescale 1ns/1ps
`default_nettype none
module cpsr_regs_chk #(
  parameter PC_WIDTH = 12
) (
  // clock and reset
  input wire logic                CLOCK_IN,
  input wire logic                RST_N_IN,
  // core requests
  input wire logic                ALU_EN_IN,
  input wire logic [3:0]          ALU_OP_IN,
  input wire logic                STORE_EN_IN,
  input wire logic [2:0]          STORE_SEL_IN,
  input wire logic                TABLE_RD_IN,
  input wire logic [15:0]         TABLE_WORD_IN,
  input wire logic                CLEAR_WATCHDOG_INSTRUCTION_IN,
  input wire logic                SLEEP_IN,
  input wire logic                WDT_EXPIRE_IN,
  // register outputs
  input wire logic [7:0]          ACC_OUT,
  input wire logic [PC_WIDTH-1:0] PC_OUT,
  input wire logic [7:0]          TABLE_LOW_OUT,
  input wire logic                TABLE_LOW_VLD_OUT,
  input wire logic [7:0]          FLAGS_OUT,
  input wire logic                DUMMY_CYCLE_OUT
);
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (!RST_N_IN);
  // only the core store is watched; a bus write to pc low loses to it
  wire pc_st = STORE_EN_IN && STORE_SEL_IN == 3'h1;
  wire sys_ev = SLEEP_IN || CLEAR_WATCHDOG_INSTRUCTION_IN || WDT_EXPIRE_IN;
  a_flag_top_zero: assert property (FLAGS_OUT[7:6] == 2'h0)
    else $error("flag bits 7:6 not zero");
  a_pc_in_page: assert property (pc_st |=> PC_OUT[7:0] == $past(ACC_OUT)
    && PC_OUT[PC_WIDTH-1:8] == $past(PC_OUT[PC_WIDTH-1:8]))
    else $error("pc low store left the page");
  a_dummy_pulse: assert property (pc_st |=> DUMMY_CYCLE_OUT
    ##1 !DUMMY_CYCLE_OUT)
    else $error("no single dummy cycle after jump");
  a_table_low: assert property (TABLE_RD_IN |=> TABLE_LOW_VLD_OUT
    && TABLE_LOW_OUT == $past(TABLE_WORD_IN[7:0]))
    else $error("table low byte wrong");
  a_zero_track: assert property (ALU_EN_IN && ALU_OP_IN != 4'h7
    && ALU_OP_IN != 4'h8 |=> FLAGS_OUT[2] == (ACC_OUT == 8'h00))
    else $error("zero flag disagrees with result");
  a_sleep_sets: assert property (SLEEP_IN && !WDT_EXPIRE_IN
    |=> FLAGS_OUT[5:4] == 2'b01)
    else $error("sleep flags wrong");
  a_clear_sys: assert property (CLEAR_WATCHDOG_INSTRUCTION_IN && !SLEEP_IN
    && !WDT_EXPIRE_IN |=> FLAGS_OUT[5:4] == 2'b00)
    else $error("clear left system flags set");
  a_sys_hold: assert property (!sys_ev |=> $stable(FLAGS_OUT[5:4]))
    else $error("system flags moved without event");
  c_jump: cover property (pc_st);
  c_table: cover property (TABLE_RD_IN);
  c_expiry: cover property (WDT_EXPIRE_IN);
endmodule // cpsr_regs_chk
bind cpsr_regs cpsr_regs_chk #(.PC_WIDTH(PC_WIDTH)) u_chk (.*);
`default_nettype wire

// [tb/cpsr_core_model.sv]
// model of the execution unit that drives the core side of the block
`timescale 1ns/1ps
`default_nettype none
module cpsr_core_model (
  // clock
  input  wire logic       clk_in,
  // pulses: alu, store, inc, dec, table, clear, sleep, expiry
  output var  logic [7:0]  go_out,
  // qualifiers of the pulses
  output var  logic [3:0]  op_out,
  output var  logic [7:0]  val_out,
  output var  logic [15:0] word_out
);
  initial begin
    go_out = 8'h00;
    op_out = 4'h0;
    val_out = 8'h00;
    word_out = 16'h0000;
  end
  // one request per call; stores only ever move the accumulator
  task automatic issue(input int k, input int op, input int v, input int w);
    @(posedge clk_in);
    go_out[k] <= 1'b1;
    op_out <= op[3:0];
    val_out <= v[7:0];
    word_out <= w[15:0];
    @(posedge clk_in);
    go_out <= 8'h00;
    // released lines show no stale value
    val_out <= ~v[7:0];
    word_out <= ~w[15:0];
  endtask
endmodule // cpsr_core_model
`default_nettype wire

// [tb/cpsr_regs_bench.sv]
// self-checking bench for the core register block
`timescale 1ns/1ps
`default_nettype none
module cpsr_regs_bench;
  logic        clk, rst_n, hsel, hwrite, pc_adv;
  logic [11:0] haddr;
  logic [1:0]  htrans;
  logic [31:0] hwdata, rd;
  wire  [31:0] hrdata;
  wire         hready, hresp, tvld, dummy;
  wire  [7:0]  acc, tlow, flags, go, val;
  wire  [11:0] pc;
  wire  [15:0] taddr, word;
  wire  [3:0]  op;
  int failures, cmp_count, m_acc, m_fl, m_sys, m_pc, m_tp, m_lat;
  cpsr_regs #(.PC_WIDTH(12)) u_dut (
    .CLOCK_IN(clk), .RST_N_IN(rst_n), .CLK_EN_IN(1'b1), .HSEL_IN(hsel),
    .HADDR_IN(haddr), .HTRANS_IN(htrans), .HWRITE_IN(hwrite),
    .HSIZE_IN(3'h2), .HWDATA_IN(hwdata), .HREADY_IN(hready),
    .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp),
    .ALU_EN_IN(go[0]), .ALU_OP_IN(op), .ALU_OPERAND_IN(val),
    .STORE_EN_IN(go[1]), .STORE_SEL_IN(op[2:0]), .TP_INC_IN(go[2]),
    .TP_DEC_IN(go[3]), .TABLE_RD_IN(go[4]), .TABLE_WORD_IN(word),
    .CLEAR_WATCHDOG_INSTRUCTION_IN(go[5]), .SLEEP_IN(go[6]), .WDT_EXPIRE_IN(go[7]),
    .PC_ADVANCE_IN(pc_adv), .ACC_OUT(acc), .PC_OUT(pc),
    .TABLE_ADDR_OUT(taddr), .TABLE_LOW_OUT(tlow),
    .TABLE_LOW_VLD_OUT(tvld), .FLAGS_OUT(flags), .DUMMY_CYCLE_OUT(dummy));
  cpsr_core_model u_core (.clk_in(clk), .go_out(go), .op_out(op),
    .val_out(val), .word_out(word));
  always #12.5 clk = ~clk;
  // compare and count; a mismatch is printed at once
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task look();
    chk("acc", m_acc, acc);
    chk("flags", m_sys << 4 | m_fl, flags);
    chk("table addr", m_tp, taddr);
    chk("pc", m_pc, pc);
  endtask
  // single word transfer, each phase held until ready is sampled high
  task ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
    chk("hresp", 0, hresp);
    #1;
  endtask
  // one core request; the model follows, then acc, flags, table address and pc compared
  task automatic step(input int k, input int o, input int v, input int w);
    int b, cin, r;
    u_core.issue(k, o, v, w);
    #1;
    if (k == 0) begin
      b = (o == 2 || o == 3) ? (~v & 255) : v;
      cin = (o == 0) ? 0 : (o == 2) ? 1 : (m_fl & 1);
      r = o == 4 ? m_acc & v : o == 5 ? m_acc | v : o == 6 ? m_acc ^ v :
          o == 9 ? v + 1 : o == 10 ? v - 1 : v;
      if (o < 4) r = m_acc + b + cin;
      if (o < 4) m_fl = ((((m_acc & 127) + (b & 127) + cin) >> 7
                  ^ r >> 8) << 3)
                  | (((m_acc & 15) + (b & 15) + cin) >> 4 << 1) | (r >> 8);
      if (o == 7) r = (m_fl & 1) << 7 | v >> 1;
      if (o == 8) r = v << 1 | m_fl & 1;
      m_fl = (o == 7) ? (m_fl & 14 | v & 1) : (o == 8) ? (m_fl & 14 | v >> 7)
           : (m_fl & 11 | ((r & 255) == 0) << 2);
      m_acc = r & 255;
    end
    if (k == 1 && o == 1) m_pc = m_pc & 'hf00 | m_acc;
    if (k == 1 && o == 2) m_tp = m_tp & 'hff00 | m_acc;
    if (k == 1 && o == 3) m_tp = m_tp & 255 | m_acc << 8;
    if (k == 1 && o == 4) m_fl = m_acc & 15;
    if (k == 2 || k == 3) m_tp = (m_tp + (k == 2 ? 1 : -1)) & 'hffff;
    if (k == 4) m_lat = w >> 8 & 255;
    if (k == 4) chk("table low", w & 255, tlow);
    if (k >= 5) m_sys = k == 5 ? 0 : k == 6 ? 1 : m_sys | 2;
    chk("dummy", k == 1 && o == 1, dummy);
    chk("table vld", k == 4, tvld);
    look();
  endtask
  task close_out();
    if (failures == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // a hang is cut short far beyond the expected run of under 20 us
  initial begin
    #100us;
    failures++;
    close_out();
  end
  initial begin
    clk = 0;
    rst_n = 0;
    {hsel, hwrite, pc_adv, haddr, htrans, hwdata} = '0;
    void'($urandom(32'he25cca2a));
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    // pc counts a known span so its page bits are no longer zero
    pc_adv <= 1'b1;
    repeat (300) @(posedge clk);
    pc_adv <= 1'b0;
    m_pc = 300;
    ahb(0, 12'h014, 0);
    chk("flag reset", 0, rd);
    step(0, 11, 128, 0);
    step(0, 0, 128, 0);
    for (int i = 0; i < 48; i++) step(0, i % 12, $urandom % 256, 0);
    // pointer pair around the low byte boundary
    step(0, 11, 255, 0);
    step(1, 2, 0, 0);
    step(0, 11, 0, 0);
    step(1, 3, 0, 0);
    step(2, 0, 0, 0);
    step(3, 0, 0, 0);
    step(4, 0, 0, $urandom % 65536);
    ahb(0, 12'h010, 0);
    chk("latch", m_lat, rd);
    step(0, 11, 90, 0);
    step(1, 1, 0, 0);
    ahb(0, 12'h018, 0);
    chk("pc full", m_pc, rd);
    // system flags against writes from bus and core
    step(7, 0, 0, 0);
    ahb(1, 12'h014, 0);
    m_fl = 0;
    look();
    step(6, 0, 0, 0);
    ahb(1, 12'h014, 32'hff);
    m_fl = 15;
    look();
    step(0, 11, 58, 0);
    step(1, 4, 0, 0);
    step(5, 0, 0, 0);
    ahb(1, 12'h000, 32'hc3);
    m_acc = 195;
    ahb(0, 12'h000, 0);
    chk("acc read", m_acc, rd);
    ahb(1, 12'h01c, 32'hffffffff);
    ahb(0, 12'h01c, 0);
    chk("unmapped", 0, rd);
    look();
    close_out();
  end
endmodule // cpsr_regs_bench
`default_nettype wire
